/* File: mbrd_pkg.sv */
/*
  constants and types of the memory block remap decoder, and the small
  position register that holds one block's placement.
  assumes one clock domain, asynchronous active-high reset, and a core
  write port that drives the position writes on the same clock.
*/
// What this block does
// - three position registers place registers, RAM, EEPROM
// - 1K EEPROM aliases in both window halves
// - large RAM: 12K block, top/bottom aligned, 4K reserved
// - large EEPROM: 4K block, lower 2K reserved
// - small RAM: 4K block, lower 2K reserved
// - values 00/39/09: registers zero, RAM top, EEPROM 0800h
// - values 30/00/39: registers 3000h, RAM zero, EEPROM 3800h
// - blocks may cover paged window 8000h-BFFFh
package mbrd_pkg;
  localparam int          ADDR_W            = 16;
  localparam int          POS_W             = 8;
  localparam int          OFFSET_W          = 13;
  // position register reset values
  localparam logic [7:0]  REG_POS_RESET     = 8'h00;
  localparam logic [7:0]  RAM_POS_RESET     = 8'h09;
  localparam logic [7:0]  EE_POS_RESET      = 8'h01;
  // field positions inside the position registers
  localparam int          REG_POS_HI        = 7;
  localparam int          REG_POS_LO        = 3;
  localparam int          RAM_REGION16_HI   = 7;
  localparam int          RAM_REGION16_LO   = 6;
  localparam int          REGION4_HI        = 7;
  localparam int          REGION4_LO        = 4;
  localparam int          RAM_ALIGN_TOP_BIT = 0;
  localparam int          EE_ENABLE_BIT     = 0;
  // paged window
  localparam logic [15:0] PAGED_LO          = 16'h8000;
  localparam logic [15:0] PAGED_HI          = 16'hBFFF;
  // sub-block codes of a 16K RAM region (4K steps)
  localparam logic [1:0]  SUB_LOW_RESERVED  = 2'h1;
  localparam logic [1:0]  SUB_HIGH_RESERVED = 2'h2;
  localparam logic [1:0]  SUB_BOTTOM        = 2'h0;
  localparam logic [1:0]  SUB_TOP           = 2'h3;

  typedef enum {
    MBRD_LARGE,
    MBRD_MID,
    MBRD_SMALL
  } mbrd_variant_type;

  typedef enum {
    MBRD_NONE,
    MBRD_REGISTERS,
    MBRD_RAM,
    MBRD_EEPROM,
    MBRD_RESERVED,
    MBRD_PAGED
  } mbrd_region_type;
endpackage : mbrd_pkg

////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module mbrd_position_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       write_enable,
  input  wire logic [7:0] write_data,
  output logic      [7:0] position
);
  // one block's placement, rewritten by the core at any time
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      position <= RESET_VALUE;
    end else if (write_enable) begin
      position <= write_data;
    end
  end
endmodule : mbrd_position_reg

/* File: mbrd_decoder.sv */
/*
  memory block remap decoder: places the register block, the internal RAM
  and the internal EEPROM in the 64K CPU space from three position
  registers and reports, one clock after each access, which block answers.
  assumes the CPU address and the position writes come from logic on the
  same clock; the variant parameter fixes the array sizes.
*/
`timescale 1ns/1ps
module mbrd_decoder #(
  parameter mbrd_pkg::mbrd_variant_type VARIANT = mbrd_pkg::MBRD_LARGE
) (
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire logic                          cpu_access,
  input  wire logic [mbrd_pkg::ADDR_W-1:0]   cpu_addr,
  input  wire logic                          register_block_position_we,
  input  wire logic                          ram_block_position_we,
  input  wire logic                          eeprom_block_position_we,
  input  wire logic [mbrd_pkg::POS_W-1:0]    position_wdata,
  output logic      [mbrd_pkg::POS_W-1:0]    register_block_position,
  output logic      [mbrd_pkg::POS_W-1:0]    ram_block_position,
  output logic      [mbrd_pkg::POS_W-1:0]    eeprom_block_position,
  output logic                               decode_valid,
  output logic                               hit_registers,
  output logic                               hit_ram,
  output logic                               hit_eeprom,
  output logic                               hit_reserved,
  output logic                               hit_paged,
  output logic                               hit_unmapped,
  output logic                               eeprom_protect_field,
  output logic      [mbrd_pkg::OFFSET_W-1:0] array_offset
);
  import mbrd_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic match4(input logic [3:0] addr_bits,
                                  input logic [3:0] pos_bits);
    match4 = (addr_bits == pos_bits);
  endfunction : match4

  function automatic logic all_ones(input logic [6:0] bits,
                                    input logic [6:0] used_mask);
    all_ones = ((bits & used_mask) == used_mask);
  endfunction : all_ones

  //////////////////////////////////////////////////////////////////////////////
  // position registers
  mbrd_position_reg #(
    .RESET_VALUE (REG_POS_RESET)
  ) u_register_position (
    .clock        (clock),
    .rst          (rst),
    .write_enable (register_block_position_we),
    .write_data   (position_wdata),
    .position     (register_block_position)
  );

  mbrd_position_reg #(
    .RESET_VALUE (RAM_POS_RESET)
  ) u_ram_position (
    .clock        (clock),
    .rst          (rst),
    .write_enable (ram_block_position_we),
    .write_data   (position_wdata),
    .position     (ram_block_position)
  );

  mbrd_position_reg #(
    .RESET_VALUE (EE_POS_RESET)
  ) u_eeprom_position (
    .clock        (clock),
    .rst          (rst),
    .write_enable (eeprom_block_position_we),
    .write_data   (position_wdata),
    .position     (eeprom_block_position)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register block: 1K at any 2K boundary
  wire logic reg_hit;
  assign reg_hit = (cpu_addr[15:11] == register_block_position[REG_POS_HI:REG_POS_LO])
                   && !cpu_addr[10];

  //////////////////////////////////////////////////////////////////////////////
  // RAM
  wire logic       ram_align_top;
  wire logic [1:0] ram_sub;
  wire logic       ram_region16;
  wire logic       ram_region4;
  assign ram_align_top = ram_block_position[RAM_ALIGN_TOP_BIT];
  assign ram_sub       = cpu_addr[13:12];
  assign ram_region16  = (cpu_addr[15:14] ==
                          ram_block_position[RAM_REGION16_HI:RAM_REGION16_LO]);
  assign ram_region4   = match4(cpu_addr[15:12],
                                ram_block_position[REGION4_HI:REGION4_LO]);

  // large: 12K block in a 16K region, 4K reserved on the side away from the
  // alignment edge, so top alignment ends at the region top and bottom
  // alignment starts at the region base
  wire logic large_ram_array;
  wire logic large_ram_reserved;
  assign large_ram_array    = ram_region16 &&
                              (ram_align_top ? ram_sub[1] : !ram_sub[1]);
  assign large_ram_reserved = ram_region16 &&
                              (ram_align_top ? (ram_sub == SUB_LOW_RESERVED)
                                             : (ram_sub == SUB_HIGH_RESERVED));

  // small: 4K block, lower 2K reserved
  wire logic small_ram_array;
  wire logic small_ram_reserved;
  assign small_ram_array    = ram_region4 && cpu_addr[11];
  assign small_ram_reserved = ram_region4 && !cpu_addr[11];

  wire logic                ram_array;
  wire logic                ram_reserved;
  wire logic [OFFSET_W-1:0] ram_offset;
  assign ram_array    = (VARIANT == MBRD_LARGE) ? large_ram_array :
                        (VARIANT == MBRD_MID)   ? ram_region4     : small_ram_array;
  assign ram_reserved = (VARIANT == MBRD_LARGE) ? large_ram_reserved :
                        (VARIANT == MBRD_MID)   ? 1'b0               : small_ram_reserved;
  // sub bit 0 picks the upper or lower 4K of the 8K array in both alignments
  assign ram_offset   = (VARIANT == MBRD_LARGE) ? {ram_sub[0], cpu_addr[11:0]} :
                        (VARIANT == MBRD_MID)   ? {1'b0, cpu_addr[11:0]} :
                                                  {2'b00, cpu_addr[10:0]};

  //////////////////////////////////////////////////////////////////////////////
  // EEPROM: window in the upper 2K of a 4K-aligned block
  wire logic ee_enabled;
  wire logic ee_region;
  assign ee_enabled = eeprom_block_position[EE_ENABLE_BIT];
  assign ee_region  = ee_enabled &&
                      match4(cpu_addr[15:12], eeprom_block_position[REGION4_HI:REGION4_LO]);

  wire logic                ee_array;
  wire logic                ee_reserved;
  wire logic [OFFSET_W-1:0] ee_offset;
  wire logic                ee_protect;
  assign ee_array    = ee_region && cpu_addr[11];
  assign ee_reserved = ee_region && !cpu_addr[11] && (VARIANT == MBRD_LARGE);
  // 1K array drops address bit 10, answering in both halves of the window
  assign ee_offset   = (VARIANT == MBRD_LARGE) ? {2'b00, cpu_addr[10:0]}
                                               : {3'b000, cpu_addr[9:0]};
  // top 16 bytes of each answering copy
  assign ee_protect  = ee_array &&
                       all_ones(cpu_addr[10:4],
                                (VARIANT == MBRD_LARGE) ? 7'h7F : 7'h3F);

  //////////////////////////////////////////////////////////////////////////////
  // priority: registers, RAM, EEPROM, then paged window
  wire logic paged_window;
  assign paged_window = (cpu_addr >= PAGED_LO) && (cpu_addr <= PAGED_HI);

  mbrd_region_type next_region;
  always_comb begin
    if (reg_hit) begin
      next_region = MBRD_REGISTERS;
    end else if (ram_array) begin
      next_region = MBRD_RAM;
    end else if (ram_reserved) begin
      next_region = MBRD_RESERVED;
    end else if (ee_array) begin
      next_region = MBRD_EEPROM;
    end else if (ee_reserved) begin
      next_region = MBRD_RESERVED;
    end else if (paged_window) begin
      next_region = MBRD_PAGED;
    end else begin
      next_region = MBRD_NONE;
    end
  end

  wire logic [OFFSET_W-1:0] next_offset;
  wire logic                next_protect;
  assign next_offset  = (next_region == MBRD_RAM)    ? ram_offset :
                        (next_region == MBRD_EEPROM) ? ee_offset  :
                        (next_region == MBRD_REGISTERS) ? {3'b000, cpu_addr[9:0]} :
                        {OFFSET_W{1'b0}};
  assign next_protect = (next_region == MBRD_EEPROM) && ee_protect;

  //////////////////////////////////////////////////////////////////////////////
  // registered answer
  mbrd_region_type region;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      region <= MBRD_NONE;
    end else if (cpu_access) begin
      region <= next_region;
    end else begin
      region <= MBRD_NONE;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      decode_valid         <= 1'b0;
      array_offset         <= {OFFSET_W{1'b0}};
      eeprom_protect_field <= 1'b0;
    end else begin
      decode_valid         <= cpu_access;
      array_offset         <= cpu_access ? next_offset : {OFFSET_W{1'b0}};
      eeprom_protect_field <= cpu_access && next_protect;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hit_registers <= 1'b0;
      hit_ram       <= 1'b0;
      hit_eeprom    <= 1'b0;
      hit_reserved  <= 1'b0;
      hit_paged     <= 1'b0;
      hit_unmapped  <= 1'b0;
    end else begin
      hit_registers <= cpu_access && (next_region == MBRD_REGISTERS);
      hit_ram       <= cpu_access && (next_region == MBRD_RAM);
      hit_eeprom    <= cpu_access && (next_region == MBRD_EEPROM);
      hit_reserved  <= cpu_access && (next_region == MBRD_RESERVED);
      hit_paged     <= cpu_access && (next_region == MBRD_PAGED);
      hit_unmapped  <= cpu_access && (next_region == MBRD_NONE);
    end
  end

  // region mirrors the hit flags for debug visibility inside the block
  wire logic unused_region;
  assign unused_region = (region == MBRD_NONE);
endmodule : mbrd_decoder

/* File: mbrd_decoder_checker.sv */
/*
  port checker of the remap decoder; the variant comes from the bound instance.
  assumes it is bound to the decoder top with every port connected by name.
*/
`timescale 1ns/1ps
module mbrd_decoder_checker #(
  parameter mbrd_pkg::mbrd_variant_type VARIANT = mbrd_pkg::MBRD_LARGE
) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        cpu_access,
  input wire logic [15:0] cpu_addr,
  input wire logic        register_block_position_we,
  input wire logic        ram_block_position_we,
  input wire logic        eeprom_block_position_we,
  input wire logic [7:0]  position_wdata,
  input wire logic [7:0]  register_block_position,
  input wire logic [7:0]  ram_block_position,
  input wire logic [7:0]  eeprom_block_position,
  input wire logic        decode_valid,
  input wire logic        hit_registers,
  input wire logic        hit_ram,
  input wire logic        hit_eeprom,
  input wire logic        hit_reserved,
  input wire logic        hit_paged,
  input wire logic        hit_unmapped,
  input wire logic        eeprom_protect_field,
  input wire logic [12:0] array_offset
);
  import mbrd_pkg::*;
  logic [5:0] hits;
  assign hits = {hit_registers, hit_ram, hit_eeprom, hit_reserved, hit_paged, hit_unmapped};
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  valid_follow_a: assert property (cpu_access |=> decode_valid)
    else $error("no decode after access");
  idle_quiet_a: assert property (!cpu_access |=> !decode_valid && hits == 6'h00)
    else $error("decode without access");
  hits_onehot_a: assert property (decode_valid |-> $onehot(hits))
    else $error("hits not one-hot");
  reg_win_a: assert property (cpu_access
    && cpu_addr[15:11] == register_block_position[7:3]
    && !cpu_addr[10] |=> hit_registers && array_offset == {3'h0, $past(cpu_addr[9:0])})
    else $error("register block not answering");
  pos_load_a: assert property (register_block_position_we |=>
    register_block_position == $past(position_wdata))
    else $error("position not loaded");
  ram_hold_a: assert property (!ram_block_position_we |=> $stable(ram_block_position))
    else $error("position changed without write");
  ee_protect_a: assert property (eeprom_protect_field |-> hit_eeprom
    && array_offset[10:4] == ((VARIANT == MBRD_LARGE) ? 7'h7F : 7'h3F))
    else $error("protect flag outside top bytes");
  paged_only_a: assert property (cpu_access
    && !(cpu_addr inside {[PAGED_LO:PAGED_HI]}) |=> !hit_paged)
    else $error("paged hit outside window");
  offset_clear_a: assert property (decode_valid
    && !(hit_registers || hit_ram || hit_eeprom) |-> array_offset == 13'h0000)
    else $error("offset on a non-array hit");
  ram_res_a: assert property (VARIANT == MBRD_LARGE && cpu_access
    && cpu_addr[15:14] == ram_block_position[7:6]
    && ram_block_position[0] && cpu_addr[13:12] == 2'h1
    && cpu_addr[15:10] != {register_block_position[7:3], 1'b0} |=> hit_reserved)
    else $error("reserved ram quarter not reserved");
  small_res_a: assert property (VARIANT == MBRD_SMALL && cpu_access
    && cpu_addr[15:12] == ram_block_position[7:4] && !cpu_addr[11]
    && cpu_addr[15:10] != {register_block_position[7:3], 1'b0} |=> hit_reserved)
    else $error("reserved ram half not reserved");
endmodule : mbrd_decoder_checker

/* File: mbrd_decoder_tb.sv */
/*
  self-checking bench of the remap decoder, large and small variants side by
  side on the same stimulus: reference decode,
  fixed placements with edge probes, then seeded random traffic.
  assumes answers one cycle after each taking edge.
*/
`timescale 1ns/1ps
module mbrd_decoder_tb;
  import mbrd_pkg::*;
  logic        clock, rst, cpu_access, register_block_position_we;
  logic        ram_block_position_we, eeprom_block_position_we;
  logic        decode_valid, hit_registers, hit_ram, hit_eeprom;
  logic        hit_reserved, hit_paged, hit_unmapped, eeprom_protect_field;
  logic [15:0] cpu_addr;
  logic [7:0]  position_wdata, register_block_position, ram_block_position;
  logic [7:0]  eeprom_block_position, m_reg, m_ram, m_ee;
  logic [12:0] array_offset;
  logic        s_valid, s_reg, s_ram, s_ee, s_res, s_paged, s_unm, s_prot;
  logic [12:0] s_offset;
  logic [20:0] exp_q;
  logic [20:0] exp_s;
  logic [31:0] r;
  int          n_fail, comparisons;
  logic [23:0] cfg [4] = '{24'h003909,
                           24'h300039,
                           24'h208181,
                           24'h2001F0};
  logic [15:0] probe [24] = '{16'h0000, 16'h03FF, 16'h0400, 16'h07FF, 16'h0800, 16'h0FF0,
    16'h1000, 16'h1FFF, 16'h2000, 16'h23FF, 16'h2400, 16'h3000, 16'h37FF, 16'h3C05,
    16'h3FF0, 16'h4000, 16'h8000, 16'h8800, 16'h8FF5, 16'h9000, 16'hA000, 16'hBFFF,
    16'hC000, 16'hFFFF};
  mbrd_decoder i_mbrd_decoder (.clock(clock), .rst(rst), .cpu_access(cpu_access),
    .cpu_addr(cpu_addr), .register_block_position_we(register_block_position_we),
    .ram_block_position_we(ram_block_position_we),
    .eeprom_block_position_we(eeprom_block_position_we), .position_wdata(position_wdata),
    .register_block_position(register_block_position),
    .ram_block_position(ram_block_position), .eeprom_block_position(eeprom_block_position),
    .decode_valid(decode_valid), .hit_registers(hit_registers), .hit_ram(hit_ram),
    .hit_eeprom(hit_eeprom), .hit_reserved(hit_reserved), .hit_paged(hit_paged),
    .hit_unmapped(hit_unmapped), .eeprom_protect_field(eeprom_protect_field),
    .array_offset(array_offset));
  mbrd_decoder #(.VARIANT(MBRD_SMALL)) i_mbrd_decoder_small (.clock(clock), .rst(rst),
    .cpu_access(cpu_access), .cpu_addr(cpu_addr),
    .register_block_position_we(register_block_position_we),
    .ram_block_position_we(ram_block_position_we),
    .eeprom_block_position_we(eeprom_block_position_we), .position_wdata(position_wdata),
    .register_block_position(), .ram_block_position(), .eeprom_block_position(),
    .decode_valid(s_valid), .hit_registers(s_reg), .hit_ram(s_ram), .hit_eeprom(s_ee),
    .hit_reserved(s_res), .hit_paged(s_paged), .hit_unmapped(s_unm),
    .eeprom_protect_field(s_prot), .array_offset(s_offset));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [20:0] expect_decode(input logic [15:0] a);
    logic [5:0]  h;
    logic [12:0] off;
    logic        p;
    logic        in_ram;
    logic        in_ee;
    off = 13'h0000;
    p = 1'b0;
    in_ram = a[15:14] == m_ram[7:6];
    in_ee = a[15:12] == m_ee[7:4] && m_ee[0];
    if (a[15:11] == m_reg[7:3] && !a[10]) begin
      h = 6'h20;
      off = {3'h0, a[9:0]};
    end else if (in_ram && (m_ram[0] ? a[13] : !a[13])) begin
      h = 6'h10;
      off = a[12:0];
    end else if (in_ram && a[13:12] == (m_ram[0] ? 2'h1 : 2'h2)) begin
      h = 6'h04;
    end else if (in_ee && a[11]) begin
      h = 6'h08;
      off = {2'h0, a[10:0]};
      p = &a[10:4];
    end else if (in_ee) begin
      h = 6'h04;
    end else begin
      h = a[15:14] == 2'h2 ? 6'h02 : 6'h01;
    end
    return {1'b1, h, p, off};
  endfunction : expect_decode
  // small variant: 2K RAM in the upper half of its 4K block, 1K EEPROM aliased
  function automatic logic [20:0] expect_small(input logic [15:0] a);
    logic [5:0]  h;
    logic [12:0] off;
    logic        p;
    off = 13'h0000;
    p = 1'b0;
    if (a[15:11] == m_reg[7:3] && !a[10]) begin
      h = 6'h20;
      off = {3'h0, a[9:0]};
    end else if (a[15:12] == m_ram[7:4]) begin
      h = a[11] ? 6'h10 : 6'h04;
      off = a[11] ? {2'h0, a[10:0]} : 13'h0000;
    end else if (a[15:12] == m_ee[7:4] && m_ee[0] && a[11]) begin
      h = 6'h08;
      off = {3'h0, a[9:0]};
      p = &a[9:4];
    end else begin
      h = a[15:14] == 2'h2 ? 6'h02 : 6'h01;
    end
    return {1'b1, h, p, off};
  endfunction : expect_small
  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    comparisons++;
    if (seen !== want) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic finish_test;
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic write_pos(input int which, input logic [7:0] v);
    @(posedge clock);
    register_block_position_we <= which == 0;
    ram_block_position_we <= which == 1;
    eeprom_block_position_we <= which == 2;
    position_wdata <= v;
  endtask : write_pos
  task automatic sweep;
    foreach (probe[j]) begin
      @(posedge clock);
      register_block_position_we <= 1'b0;
      ram_block_position_we <= 1'b0;
      eeprom_block_position_we <= 1'b0;
      cpu_access <= 1'b1;
      cpu_addr <= probe[j];
    end
    @(posedge clock);
    cpu_access <= 1'b0;
  endtask : sweep
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      exp_q <= 21'h0;
      exp_s <= 21'h0;
      m_reg <= REG_POS_RESET;
      m_ram <= RAM_POS_RESET;
      m_ee <= EE_POS_RESET;
    end else begin
      exp_q <= cpu_access ? expect_decode(cpu_addr) : 21'h0;
      exp_s <= cpu_access ? expect_small(cpu_addr) : 21'h0;
      if (register_block_position_we) m_reg <= position_wdata;
      if (ram_block_position_we) m_ram <= position_wdata;
      if (eeprom_block_position_we) m_ee <= position_wdata;
    end
  end
  always @(negedge clock) begin
    if (!rst) begin
      check(24'({decode_valid, hit_registers, hit_ram, hit_eeprom, hit_reserved, hit_paged,
        hit_unmapped}), 24'(exp_q[20:14]));
      check(24'(eeprom_protect_field), 24'(exp_q[13]));
      check(24'(array_offset), 24'(exp_q[12:0]));
      check({register_block_position, ram_block_position, eeprom_block_position},
        {m_reg, m_ram, m_ee});
      check(24'({s_valid, s_reg, s_ram, s_ee, s_res, s_paged, s_unm}), 24'(exp_s[20:14]));
      check(24'({s_prot, s_offset}), 24'(exp_s[13:0]));
    end
  end
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    finish_test();
  end
  initial begin
    {rst, cpu_access, register_block_position_we, ram_block_position_we} = 4'h8;
    {eeprom_block_position_we, position_wdata, cpu_addr} = 25'h0;
    r = $urandom(73007);
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    cpu_access <= 1'b0;
    register_block_position_we <= 1'b0;
    ram_block_position_we <= 1'b0;
    sweep();
    foreach (cfg[i]) begin
      for (int k = 0; k < 3; k++) write_pos(k, cfg[i][23 - 8 * k -: 8]);
      sweep();
    end
    repeat (4000) begin
      @(posedge clock);
      r = $urandom;
      cpu_access <= r[0];
      cpu_addr <= r[31:16];
      position_wdata <= r[15:8];
      register_block_position_we <= r[4:1] == 4'h1 || r[4:1] == 4'hF;
      ram_block_position_we <= r[4:1] == 4'h2 || r[4:1] == 4'hF;
      eeprom_block_position_we <= r[4:1] == 4'h3 || r[4:1] == 4'hF;
    end
    cpu_access <= 1'b0;
    {register_block_position_we, ram_block_position_we, eeprom_block_position_we} <= 3'h0;
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    sweep();
    finish_test();
  end
endmodule : mbrd_decoder_tb
bind mbrd_decoder mbrd_decoder_checker #(.VARIANT(VARIANT)) i_mbrd_decoder_checker (
  .clock(clock), .rst(rst), .cpu_access(cpu_access), .cpu_addr(cpu_addr),
  .register_block_position_we(register_block_position_we),
  .ram_block_position_we(ram_block_position_we),
  .eeprom_block_position_we(eeprom_block_position_we), .position_wdata(position_wdata),
  .register_block_position(register_block_position),
  .ram_block_position(ram_block_position), .eeprom_block_position(eeprom_block_position),
  .decode_valid(decode_valid), .hit_registers(hit_registers), .hit_ram(hit_ram),
  .hit_eeprom(hit_eeprom), .hit_reserved(hit_reserved), .hit_paged(hit_paged),
  .hit_unmapped(hit_unmapped), .eeprom_protect_field(eeprom_protect_field),
  .array_offset(array_offset));
